// *** rsc_regs.svh ***
/*
  Constants of the system reset controller: flag positions, reset values and timing counts.
  Assumes a 125 MHz system clock; included by the package and by the design modules.
*/
//----------------------------------------------------------------------
// What this block does
//----------------------------------------------------------------------
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

//----------------------------------------------------------------------
// reset cause flag positions
//----------------------------------------------------------------------
`define RSC_FLAG_POR      0
`define RSC_FLAG_EXT      1
`define RSC_FLAG_BOD      2
`define RSC_FLAG_WDT      3
`define RSC_FLAG_TC       4
`define RSC_FLAG_W        5
`define RSC_FLAG_RST      5'h01

//----------------------------------------------------------------------
// timing
//----------------------------------------------------------------------
`define RSC_CLK_MHZ       125
`define RSC_T_RST_NS      1500
`define RSC_T_RST_CYC     ((`RSC_T_RST_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_PIN_CNT_W     8
`define RSC_DLY_W         16
`define RSC_DLY_BASE      16'h0040
`define RSC_FUSE_W        4

`endif

// *** rsc_pkg.sv ***
/*
  Types of the system reset controller.
  Assumes rsc_regs.svh is on the include path.
*/
`include "rsc_regs.svh"

package rsc_pkg;

  // reset requests as they arrive, asynchronous except the watchdog expiry
  typedef struct packed {
    logic test_chain_bit;   // test chain reset register
    logic bod_below;        // brown-out detector output
    logic wdt_expire;       // watchdog period expired, system clock domain
    logic por_below;        // supply below power-on threshold
  } rsc_src_type;

  typedef struct packed {
    logic test_chain_flag;
    logic watchdog_flag;
    logic brownout_flag;
    logic external_pin_flag;
    logic power_on_flag;
  } rsc_cause_type;

  typedef enum logic [1:0] {
    RSC_HOLD,
    RSC_DELAY,
    RSC_RUN
  } rsc_state_type;

endpackage : rsc_pkg

// *** rsc_pin_filter.sv ***
/*
  Qualifier for the external reset pin: synchronises the pin and reports a reset once it
  has stayed low for the minimum pulse width. Assumes a free-running system clock.
*/
`timescale 1ns/1ps
`include "rsc_regs.svh"

module rsc_pin_filter (
  input  wire logic clk,            // system clock
  input  wire logic rst_b,          // async reset, active low
  input  wire logic pin_b,          // external reset pin, active low
  output logic      pin_reset       // qualified pin reset, level
);

  localparam logic [`RSC_PIN_CNT_W-1:0] MIN_CYC = `RSC_PIN_CNT_W'(`RSC_T_RST_CYC);

  logic                      meta_ff;
  logic                      sync_ff;
  logic [`RSC_PIN_CNT_W-1:0] cnt_ff;
  logic [`RSC_PIN_CNT_W-1:0] nxt_cnt;
  logic                      hit_ff;
  logic                      nxt_hit;

  //----------------------------------------------------------------------
  // low-time count
  //----------------------------------------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_hit = hit_ff;
    if (sync_ff) begin
      nxt_cnt = '0;
      nxt_hit = 1'b0;
    end else if (cnt_ff != MIN_CYC) begin
      nxt_cnt = cnt_ff + `RSC_PIN_CNT_W'(1);
    end else begin
      nxt_hit = 1'b1;
    end
  end

  // pin idles high, so the synchroniser resets to one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      cnt_ff  <= '0;
      hit_ff  <= 1'b0;
    end else begin
      meta_ff <= pin_b;
      sync_ff <= meta_ff;
      cnt_ff  <= nxt_cnt;
      hit_ff  <= nxt_hit;
    end
  end

  assign pin_reset = hit_ff;

endmodule : rsc_pin_filter

// *** rsc_ctrl.sv ***
/*
  System reset controller: merges the five reset sources, drives the port reset with only the watchdog pulse clocked,
  stretches the internal reset by a fuse-selected delay and keeps the reset cause flags.
  Assumes the watchdog expiry input is on this clock; all other sources are asynchronous.
*/
`timescale 1ns/1ps
`include "rsc_regs.svh"

module rsc_ctrl #(
  parameter logic [`RSC_DLY_W-1:0] DLY_BASE = `RSC_DLY_BASE   // shortest stretch, cycles
) (
  input  wire logic                   clk,                // system clock
  input  wire logic                   rst_b,              // async reset of this logic, active low
  input  wire rsc_pkg::rsc_src_type   src,                // reset sources except the pin
  input  wire logic                   ext_pin_b,          // external reset pin, active low
  input  wire logic                   wdt_enable,         // watchdog enabled
  input  wire logic                   bod_enable,         // brown-out detection enabled
  input  wire logic [`RSC_FUSE_W-1:0] clock_select_fuses, // stretch length select
  input  wire logic                   flag_wr,            // software write of the cause flags
  input  wire rsc_pkg::rsc_cause_type flag_wr_data,       // value written, zero clears
  output logic                        port_reset_b,       // I/O port reset, async, active low
  output logic                        io_reset_b,         // stretched internal reset, active low
  output logic                        vector_fetch,       // one-cycle start at the reset vector
  output rsc_pkg::rsc_cause_type      reset_cause_register, // cause flags
  output rsc_pkg::rsc_state_type      state               // sequencer state
);

  import rsc_pkg::*;

  //----------------------------------------------------------------------
  // terminal count from the fuses
  //----------------------------------------------------------------------
  // upper fuse pair scales by powers of four, lower pair adds quarters
  function automatic logic [`RSC_DLY_W-1:0] dly_term(input logic [`RSC_FUSE_W-1:0] sel);
    logic [`RSC_DLY_W-1:0] base;
    base = '0;
    unique case (sel[3:2])
      2'h0: base = DLY_BASE;
      2'h1: base = DLY_BASE << 2;
      2'h2: base = DLY_BASE << 4;
      2'h3: base = DLY_BASE << 6;
    endcase
    dly_term = base + ((base >> 2) * `RSC_DLY_W'(sel[1:0]));
  endfunction : dly_term

  //----------------------------------------------------------------------
  // synchronisers for asynchronous sources
  //----------------------------------------------------------------------
  localparam int NSYNC = 3;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;
  logic             por_s;
  logic             bod_s;
  logic             tc_s;
  logic             ext_s;

  assign async_in = {src.test_chain_bit, src.bod_below, src.por_below};

  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end else begin
          meta_ff[i] <= async_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign por_s = sync_ff[0];
  assign bod_s = sync_ff[1] & bod_enable;
  assign tc_s  = sync_ff[2];

  rsc_pin_filter u_pin (
    .clk       (clk),
    .rst_b     (rst_b),
    .pin_b     (ext_pin_b),
    .pin_reset (ext_s)
  );

  //----------------------------------------------------------------------
  // watchdog pulse
  //----------------------------------------------------------------------
  logic wdt_dly_ff;
  logic nxt_wdt_dly;
  logic wdt_pulse_ff;
  logic nxt_wdt_pulse;

  // a held expiry still yields only one cycle of reset
  always_comb begin
    nxt_wdt_dly   = src.wdt_expire;
    nxt_wdt_pulse = src.wdt_expire & ~wdt_dly_ff & wdt_enable;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_dly_ff   <= 1'b0;
      wdt_pulse_ff <= 1'b0;
    end else begin
      wdt_dly_ff   <= nxt_wdt_dly;
      wdt_pulse_ff <= nxt_wdt_pulse;
    end
  end

  //----------------------------------------------------------------------
  // port reset, no clock in the path except the watchdog pulse
  //----------------------------------------------------------------------
  // raw asynchronous sources on purpose: the ports must follow even with the clock stopped
  assign port_reset_b = ~(src.por_below | ~ext_pin_b | (src.bod_below & bod_enable)
                          | src.test_chain_bit | wdt_pulse_ff | ~rst_b);

  //----------------------------------------------------------------------
  // sequencer
  //----------------------------------------------------------------------
  logic                  any_src;
  rsc_state_type         state_ff;
  rsc_state_type         nxt_state;
  logic [`RSC_DLY_W-1:0] cnt_ff;
  logic [`RSC_DLY_W-1:0] nxt_cnt;
  logic [`RSC_DLY_W-1:0] term_ff;
  logic [`RSC_DLY_W-1:0] nxt_term;
  logic                  io_rst_ff;
  logic                  nxt_io_rst;
  logic                  fetch_ff;
  logic                  nxt_fetch;

  assign any_src = por_s | ext_s | bod_s | tc_s | wdt_pulse_ff;

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_term   = term_ff;
    nxt_fetch  = 1'b0;
    nxt_io_rst = 1'b1;
    unique case (state_ff)
      RSC_HOLD: begin
        nxt_cnt  = '0;
        // fuses are caught while held so the stretch never changes mid-count
        nxt_term = dly_term(clock_select_fuses);
        if (!any_src) begin
          nxt_state = RSC_DELAY;
        end
      end
      RSC_DELAY: begin
        if (any_src) begin
          nxt_state = RSC_HOLD;
          nxt_cnt   = '0;
        end else if (cnt_ff >= term_ff - `RSC_DLY_W'(1)) begin
          nxt_state  = RSC_RUN;
          nxt_io_rst = 1'b0;
          nxt_fetch  = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + `RSC_DLY_W'(1);
        end
      end
      RSC_RUN: begin
        if (any_src) begin
          nxt_state = RSC_HOLD;
        end else begin
          nxt_io_rst = 1'b0;
        end
      end
      // the unused fourth code falls back to holding reset
      default: begin
        nxt_state = RSC_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff  <= RSC_HOLD;
      cnt_ff    <= '0;
      term_ff   <= `RSC_DLY_BASE;
      io_rst_ff <= 1'b1;
      fetch_ff  <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      term_ff   <= nxt_term;
      io_rst_ff <= nxt_io_rst;
      fetch_ff  <= nxt_fetch;
    end
  end

  assign io_reset_b   = ~io_rst_ff;
  assign vector_fetch = fetch_ff;
  assign state        = state_ff;

  //----------------------------------------------------------------------
  // reset cause flags
  //----------------------------------------------------------------------
  logic [`RSC_FLAG_W-1:0] flag_ff;
  logic [`RSC_FLAG_W-1:0] nxt_flag;
  logic [`RSC_FLAG_W-1:0] set_v;
  logic [`RSC_FLAG_W-1:0] clr_v;

  // a source event in the clearing cycle is kept: set beats clear
  always_comb begin
    set_v = '0;
    clr_v = '0;
    set_v[`RSC_FLAG_POR] = por_s;
    set_v[`RSC_FLAG_EXT] = ext_s;
    set_v[`RSC_FLAG_BOD] = bod_s;
    set_v[`RSC_FLAG_WDT] = wdt_pulse_ff;
    set_v[`RSC_FLAG_TC]  = tc_s;
    if (flag_wr) begin
      clr_v = ~flag_wr_data;
    end
    if (por_s) begin
      clr_v[`RSC_FLAG_TC:`RSC_FLAG_EXT] = '1;
    end
    nxt_flag = (flag_ff & ~clr_v) | set_v;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_ff <= `RSC_FLAG_RST;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign reset_cause_register = flag_ff;

endmodule : rsc_ctrl

// *** rsc_ctrl_assertions.sv ***
/*
  Port checker of the system reset controller, bound to every rsc_ctrl.
  Assumes one clock domain and rst_b as the only disable.
*/
`timescale 1ns/1ps
module rsc_ctrl_assertions (
  input wire logic                   clk,                  // system clock
  input wire logic                   rst_b,                // async reset
  input wire rsc_pkg::rsc_src_type   src,                  // raw sources
  input wire logic                   ext_pin_b,            // reset pin
  input wire logic                   flag_wr,              // flag write
  input wire rsc_pkg::rsc_cause_type flag_wr_data,         // flag data
  input wire logic                   port_reset_b,         // port reset
  input wire logic                   io_reset_b,           // internal reset
  input wire logic                   vector_fetch,         // start pulse
  input wire rsc_pkg::rsc_cause_type reset_cause_register, // flags
  input wire rsc_pkg::rsc_state_type state                 // sequencer
);
  import rsc_pkg::*;
  //--------------------------------------------------------------------
  // properties
  //--------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_port_src: assert property ((src.por_below || src.test_chain_bit || !ext_pin_b) |-> !port_reset_b)
    else $error("port reset not low");
  a_por_hold: assert property (src.por_below [*5] |-> !io_reset_b)
    else $error("run during power-on");
  a_tc_hold: assert property (src.test_chain_bit [*5] |-> !io_reset_b)
    else $error("run during test chain reset");
  a_vec_pulse: assert property (vector_fetch |=> !vector_fetch)
    else $error("start pulse too long");
  a_vec_rise: assert property (vector_fetch |-> $rose(io_reset_b))
    else $error("start pulse off release");
  a_delay_min: assert property ($rose(io_reset_b) |-> $past(state, 3) == RSC_DELAY)
    else $error("release without delay");
  a_por_set: assert property (src.por_below [*4] |=> reset_cause_register.power_on_flag)
    else $error("power-on flag not set");
  a_por_clear: assert property ($fell(reset_cause_register.power_on_flag) |->
    $past(flag_wr) && !$past(flag_wr_data.power_on_flag))
    else $error("power-on flag lost");
  c_start: cover property (vector_fetch);
  c_wdt: cover property (vector_fetch && reset_cause_register.watchdog_flag);
  c_drop: cover property ($fell(io_reset_b));
endmodule : rsc_ctrl_assertions

bind rsc_ctrl rsc_ctrl_assertions chk (.clk(clk), .rst_b(rst_b), .src(src), .ext_pin_b(ext_pin_b),
  .flag_wr(flag_wr), .flag_wr_data(flag_wr_data), .port_reset_b(port_reset_b), .io_reset_b(io_reset_b),
  .vector_fetch(vector_fetch), .reset_cause_register(reset_cause_register), .state(state));

// *** rsc_src_model.sv ***
/*
  Reset sources and board pin driver facing the controller.
  Assumes the caller steps set just after a rising clock edge.
*/
`timescale 1ns/1ps
module rsc_src_model (
  output rsc_pkg::rsc_src_type src,       // on-chip sources
  output logic                 ext_pin_b  // pin, active low
);
  import rsc_pkg::*;
  initial begin
    src = '0;
    ext_pin_b = 1'b1;
  end
  // k: 0 power-on, 1 pin, 2 brown-out, 3 test chain, 4 watchdog
  task set(input int k, input logic v);
    case (k)
      0: src.por_below = v;
      1: ext_pin_b = !v;
      2: src.bod_below = v;
      3: src.test_chain_bit = v;
      default: src.wdt_expire = v;
    endcase
  endtask : set
endmodule : rsc_src_model

// *** rsc_ctrl_tb_top.sv ***
/*
  Self-checking bench of rsc_ctrl with a short stretch base.
  Assumes rsc_src_model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module rsc_ctrl_tb_top;
  import rsc_pkg::*;
  logic          clk, rst_b, wdt_enable, bod_enable, flag_wr, pin_b, port_b, io_b, vec;
  logic [3:0]    fuses;
  rsc_cause_type wr_data, cause;
  rsc_src_type   src;
  rsc_state_type state;
  int            error_cnt, checked, cyc, d0, d;
  rsc_src_model m (.src(src), .ext_pin_b(pin_b));
  rsc_ctrl #(.DLY_BASE(16'h0004)) uut (.clk(clk), .rst_b(rst_b), .src(src), .ext_pin_b(pin_b),
    .wdt_enable(wdt_enable), .bod_enable(bod_enable), .clock_select_fuses(fuses), .flag_wr(flag_wr),
    .flag_wr_data(wr_data), .port_reset_b(port_b), .io_reset_b(io_b), .vector_fetch(vec),
    .reset_cause_register(cause), .state(state));
  //--------------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task finish_test();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // cycles from now to release of the internal reset
  task wait_run(output int n);
    n = 0;
    while (io_b !== 1'b1 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(vec), 16'h0001);
    @(posedge clk);
    #1;
    chk(16'(vec), 16'h0000);
  endtask : wait_run
  task pulse(input int k, input int n);
    @(posedge clk);
    #1;
    m.set(k, 1'b1);
    #1;
    if (k != 4) chk(16'(port_b), 16'(k == 2 && !bod_enable));
    repeat (n) @(posedge clk);
    #1;
    m.set(k, 1'b0);
  endtask : pulse
  task wr_flags(input rsc_cause_type v, input rsc_cause_type exp);
    @(posedge clk);
    #1;
    wr_data = v;
    flag_wr = 1'b1;
    @(posedge clk);
    #1;
    flag_wr = 1'b0;
    wr_data = '1;
    chk(16'(cause), 16'(exp));
  endtask : wr_flags
  //--------------------------------------------------------------------
  // scenarios
  //--------------------------------------------------------------------
  task t_por_fuse();
    pulse(0, 30);
    chk(16'(io_b), 16'h0000);
    wait_run(d0);
    fuses = 4'h5;
    pulse(0, 30);
    wait_run(d);
    chk(16'(d - d0), 16'h0010);
    pulse(0, 30);
    repeat (8) @(posedge clk);
    pulse(0, 2);
    wait_run(d);
    chk(16'(d - d0), 16'h0010);
    fuses = 4'hb;
    pulse(0, 30);
    wait_run(d);
    chk(16'(d - d0), 16'h006c);
    fuses = 4'he;
    pulse(0, 30);
    wait_run(d);
    chk(16'(d - d0), 16'h017c);
    fuses = 4'h0;
  endtask : t_por_fuse
  task t_gated();
    pulse(1, 20);
    repeat (200) @(posedge clk);
    #1;
    chk(16'({io_b, cause}), 16'h0021);
    pulse(4, 1);
    pulse(2, 30);
    repeat (10) @(posedge clk);
    #1;
    chk(16'({io_b, cause}), 16'h0021);
  endtask : t_gated
  task t_each(input int k, input int flag);
    pulse(k, k == 4 ? 3 : 200);
    chk(16'(io_b), 16'h0000);
    wait_run(d);
    chk(16'(cause[flag]), 16'h0001);
  endtask : t_each
  initial begin
    rst_b = 1'b0;
    wdt_enable = 1'b0;
    bod_enable = 1'b0;
    flag_wr = 1'b0;
    wr_data = '1;
    fuses = 4'h0;
    repeat (20) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_por_fuse();
    t_gated();
    wdt_enable = 1'b1;
    bod_enable = 1'b1;
    t_each(1, 1);
    t_each(2, 2);
    t_each(4, 3);
    t_each(3, 4);
    wr_flags(5'h1e, 5'h1e);
    pulse(0, 30);
    wait_run(d);
    chk(16'(cause), 16'h0001);
    wr_flags(5'h00, 5'h00);
    // mid-run reset of the controller itself
    @(posedge clk);
    #1;
    rst_b = 1'b0;
    #1;
    chk(16'({port_b, io_b, cause}), 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    wait_run(d);
    chk(16'(d), 16'h0005);
    finish_test();
  end
endmodule : rsc_ctrl_tb_top
